// ### hw/serial_port_pkg.sv
// Shared constants for the 8-bit serial shift port: register map, field
// positions, reset values, timing counts and the transfer state type.
// Assumes a core clock at the oscillator rate; one instruction = 6 clocks.
`default_nettype none
package serial_port_pkg;

  // Peripheral register port addresses (the Y' pointer value).
  localparam int          ADDR_W                 = 3;
  localparam logic [2:0]  ADDR_SERIAL_CONTROL    = 3'h1;
  localparam logic [2:0]  ADDR_SERIAL_SHIFT_DATA = 3'h2;

  // Widths of the register port and of the shift register.
  localparam int          NIBBLE_W = 4;
  localparam int          BYTE_W   = 8;

  // Control register field positions.
  localparam int          CTRL_START_BIT  = 0;
  localparam int          CTRL_EXTCLK_BIT = 1;
  localparam int          CTRL_DIR_BIT    = 3;
  localparam int          STATUS_EOT_BIT  = 0;

  // Reset values.
  localparam logic [3:0]  CTRL_RESET  = 4'h0;
  localparam logic [7:0]  SHIFT_RESET = 8'h00;
  localparam logic [2:0]  BITCNT_ZERO = 3'h0;
  localparam logic [2:0]  BITCNT_ONE  = 3'h1;
  localparam logic [2:0]  BITCNT_LAST = 3'h7;

  // Timing: core clock period, oscillator clocks per instruction and the
  // start guard expressed in instructions.
  localparam int          CLK_PERIOD_NS    = 8;
  localparam int          INSTR_OSC_CYCLES = 6;
  localparam int          GUARD_INSTR      = 2;
  localparam int          GUARD_CYCLES     = GUARD_INSTR * INSTR_OSC_CYCLES;
  localparam int          PRE_W            = 16;

  // Transfer sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_SHIFT
  } state_t;

endpackage
`default_nettype wire

// ### hw/byte_fifo.sv
// Small synchronous FIFO holding received bytes until software reads them.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointer wrap relies on a power-of-two depth.
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("byte_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array.
  logic [AW-1:0]    wrPtr;        // Next slot to fill.
  logic [AW-1:0]    rdPtr;        // Oldest entry.
  logic [AW:0]      count;        // Entries held.
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage write; no reset needed on the data array.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule
`default_nettype wire

// ### hw/serial_shift_port.sv
// Serial shift port: nibble-wide control and shift registers on the
// peripheral register port, clock and data pins toward a serial peer.
// Assumes pin inputs are synchronous to core_clk and the prescaler stop
// level arrives from the timer block as a plain input.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Control bit 0 write starts transfer.
// - External clock: wait armed for edge.
// - Control bit 3 sets bidir direction.
// - Bit order is build parameter.
// - Three-wire: drive falling, sample rising.
// - Two-wire: same pin both directions.
// - Internal clock driven; interrupt after eight.
// - Internal clock from instruction prescaler.
// - Prescaler stop freezes serial operation.
// - Register write mid-transfer aborts it.
// - Early first edge lost: seven shifts.
// - End flag set at eight, start clears.
// - Shift data written a nibble per Y.
// - Preloaded byte shifted out serially.
// - Reads return nibble chosen by Y.
// - Control read shows end flag bit 0.
// - Values 1000 then 1001 transmit internally.
module serial_shift_port
  import serial_port_pkg::*;
#(
  parameter bit MSB_FIRST    = 1'b1,
  parameter int PRESCALE_DIV = 2,
  parameter int INSTR_CYCLES = serial_port_pkg::INSTR_OSC_CYCLES,
  parameter int FIFO_DEPTH   = 8
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst,
  input  wire logic [serial_port_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [serial_port_pkg::NIBBLE_W-1:0] regWrData,
  input  wire logic                                 regWr,
  input  wire logic                                 regRd,
  input  wire logic                                 yIndexLsb,
  input  wire logic                                 prescalerStop,
  input  wire logic                                 sckIn,
  input  wire logic                                 bidirIn,
  output logic      [serial_port_pkg::NIBBLE_W-1:0] regRdData,
  output logic                                      sckOut,
  output logic                                      sckOe_n,
  output logic                                      dedicatedOut,
  output logic                                      bidirOut,
  output logic                                      bidirOe_n,
  output logic                                      serialIrq
);
  import serial_port_pkg::*;

  localparam int HALF_CYCLES = (INSTR_CYCLES * PRESCALE_DIV) / 2;

  // The prescaler only offers powers of two from 2 to 4096.
  initial begin
    if (PRESCALE_DIV < 2 || PRESCALE_DIV > 4096 || (PRESCALE_DIV & (PRESCALE_DIV - 1)) != 0
        || INSTR_CYCLES < 2 || HALF_CYCLES >= (1 << PRE_W)) begin
      $error("serial_shift_port: unsupported prescaler setting");
    end
  end

  state_t             state;        // Transfer sequencer.
  logic [3:0]         ctrl;         // Mode bits as last written.
  logic               eotFlag;      // End-of-transfer flag.
  logic [7:0]         shiftReg;     // Parallel/serial shift register.
  logic [2:0]         bitCnt;       // Serial clock counter.
  logic [PRE_W-1:0]   preCnt;       // Prescaler half-period counter.
  logic [PRE_W-1:0]   guardCnt;     // Start guard countdown.
  logic               sckPrev;      // Previous sampled clock pin level.
  logic               rxPush;       // Completed byte waiting to be queued.
  logic [7:0]         rxByte;       // Completed byte.
  logic               fifoInReady;
  logic [7:0]         fifoOutData;
  logic               fifoOutValid;
  logic               fifoPop;
  logic               extMode;
  logic               wrCtrl;
  logic               wrData;
  logic               startReq;
  logic               abortReq;
  logic               intTick;
  logic               fallEv;
  logic               riseEv;
  logic               lastShift;
  logic [7:0]         next_shift;

  assign extMode  = ctrl[CTRL_EXTCLK_BIT];
  assign wrCtrl   = regWr && (regAddr == ADDR_SERIAL_CONTROL);
  assign wrData   = regWr && (regAddr == ADDR_SERIAL_SHIFT_DATA);
  assign startReq = wrCtrl && regWrData[CTRL_START_BIT];
  assign abortReq = (wrCtrl || wrData) && (state != ST_IDLE);

  assign intTick = (preCnt == PRE_W'(HALF_CYCLES - 1));

  // stop gates every edge. edges from either clock source.
  assign fallEv = !prescalerStop && (extMode ? (sckPrev && !sckIn) : (intTick && sckOut));
  assign riseEv = !prescalerStop && (extMode ? (!sckPrev && sckIn) : (intTick && !sckOut));

  assign lastShift = (state == ST_SHIFT) && riseEv && (bitCnt == BITCNT_LAST);

  // bit order picks the shift direction. input always from bidir pin.
  assign next_shift = MSB_FIRST ? {shiftReg[6:0], bidirIn} : {bidirIn, shiftReg[7:1]};

  // Popping happens when software reads the upper nibble of a queued byte.
  assign fifoPop = regRd && (regAddr == ADDR_SERIAL_SHIFT_DATA) && yIndexLsb && fifoOutValid;

  // Control register; mode bits take effect on the write, and the pin enables follow one clock later.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl <= regWrData;
    end
  end

  // Sequencer: idle, armed waiting for guard and room, shifting.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (startReq) begin
      state <= ST_ARMED;
    end else if (abortReq || lastShift) begin
      state <= ST_IDLE;
    end else if (state == ST_ARMED && guardCnt == '0 && fifoInReady && !prescalerStop) begin
      // armed until ready for the first edge.
      state <= ST_SHIFT;
    end
  end

  // Start guard; counted in core clocks during the armed phase.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      guardCnt <= '0;
    end else if (startReq) begin
      guardCnt <= PRE_W'(GUARD_INSTR * INSTR_CYCLES);
    end else if (guardCnt != '0 && !prescalerStop) begin
      guardCnt <= guardCnt - 1'b1;
    end
  end

  // Serial clock counter; an early external falling edge costs one shift.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bitCnt <= BITCNT_ZERO;
    end else if (startReq || abortReq) begin
      bitCnt <= BITCNT_ZERO;
    end else if (state == ST_ARMED && extMode && fallEv && guardCnt != '0) begin
      bitCnt <= BITCNT_ONE;
    end else if (state == ST_SHIFT && riseEv) begin
      bitCnt <= bitCnt + 1'b1;
    end
  end

  // Shift register: nibble loads from software, one bit per rising edge.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shiftReg <= SHIFT_RESET;
    end else if (wrData) begin
      if (yIndexLsb) begin
        shiftReg[7:4] <= regWrData;
      end else begin
        shiftReg[3:0] <= regWrData;
      end
    end else if (state == ST_SHIFT && riseEv) begin
      shiftReg <= next_shift;
    end
  end

  // Outgoing data bit; each data pin has its own flop, and both load the same bit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dedicatedOut <= 1'b1;
      bidirOut     <= 1'b1;
    end else if (state == ST_SHIFT && fallEv) begin
      dedicatedOut <= MSB_FIRST ? shiftReg[7] : shiftReg[0];
      bidirOut     <= MSB_FIRST ? shiftReg[7] : shiftReg[0];
    end
  end

  // Pin directions; the enables are low while driving.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bidirOe_n <= 1'b1;
      sckOe_n   <= 1'b1;
    end else begin
      bidirOe_n <= !ctrl[CTRL_DIR_BIT];
      sckOe_n   <= extMode;
    end
  end

  // Prescaler counter; restarts from zero whenever it is stopped or idle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      preCnt <= '0;
    end else if (prescalerStop || state != ST_SHIFT || extMode || intTick) begin
      preCnt <= '0;
    end else begin
      preCnt <= preCnt + 1'b1;
    end
  end

  // Internal serial clock output.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sckOut <= 1'b1;
    end else if (state != ST_SHIFT || extMode || abortReq || lastShift) begin
      sckOut <= 1'b1;
    end else if (intTick && !prescalerStop) begin
      sckOut <= !sckOut;
    end
  end

  // External clock history for edge detection.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sckPrev <= 1'b1;
    end else begin
      sckPrev <= sckIn;
    end
  end

  // End flag and completion pulse; completion wins over a clearing start.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eotFlag   <= 1'b0;
      serialIrq <= 1'b0;
    end else begin
      serialIrq <= lastShift;
      if (lastShift) begin
        eotFlag <= 1'b1;
      end else if (startReq) begin
        eotFlag <= 1'b0;
      end
    end
  end

  // Completed byte is handed to the receive queue one cycle later.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxPush <= 1'b0;
      rxByte <= SHIFT_RESET;
    end else begin
      rxPush <= lastShift;
      if (lastShift) begin
        rxByte <= next_shift;
      end
    end
  end

  // Register reads; data reads show the oldest queued byte, else the shifter.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_SERIAL_CONTROL: regRdData <= {ctrl[CTRL_DIR_BIT], 1'b0, extMode, eotFlag};
        ADDR_SERIAL_SHIFT_DATA: begin
          if (fifoOutValid) begin
            regRdData <= yIndexLsb ? fifoOutData[7:4] : fifoOutData[3:0];
          end else begin
            regRdData <= yIndexLsb ? shiftReg[7:4] : shiftReg[3:0];
          end
        end
        default: regRdData <= '0;
      endcase
    end
  end

  // Receive queue; a full queue holds new transfers in the armed state.
  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) rx_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inData   (rxByte),
    .inValid  (rxPush),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_start;
    startReq |=> state == ST_ARMED;
  endproperty
  a_start: assert property (p_start) else $error("start not armed");

  property p_ext_wait;
    (state == ST_SHIFT && extMode && !riseEv && !wrData) |=> $stable(shiftReg);
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("shift without edge");

  property p_dir;
    ##1 bidirOe_n == !$past(ctrl[CTRL_DIR_BIT]);
  endproperty
  a_dir: assert property (p_dir) else $error("bidir enable wrong");

  property p_out_on_fall;
    !$stable(dedicatedOut) |-> $past(fallEv) && $past(state) == ST_SHIFT;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("data moved off edge");

  property p_irq;
    lastShift |=> serialIrq && eotFlag && state == ST_IDLE ##1 !serialIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("completion pulse wrong");

  property p_stop;
    prescalerStop && !wrData && !startReq && !abortReq |=> $stable(shiftReg) && $stable(bitCnt);
  endproperty
  a_stop: assert property (p_stop) else $error("moved while stopped");

  property p_abort;
    abortReq |=> bitCnt == BITCNT_ZERO;
  endproperty
  a_abort: assert property (p_abort) else $error("abort kept count");

  property p_eot_clear;
    startReq && !lastShift |=> !eotFlag;
  endproperty
  a_eot_clear: assert property (p_eot_clear) else $error("flag not cleared");

  property p_idle_high;
    (state != ST_SHIFT) |=> sckOut;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock not idle high");

  property p_nibble;
    wrData && !yIndexLsb |=> shiftReg[3:0] == $past(regWrData);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble not loaded");

  property p_cov_done;
    lastShift;
  endproperty
  c_cov_done: cover property (p_cov_done);

  property p_cov_abort;
    abortReq;
  endproperty
  c_cov_abort: cover property (p_cov_abort);

  property p_cov_missed;
    state == ST_ARMED && extMode && fallEv && guardCnt != '0;
  endproperty
  c_cov_missed: cover property (p_cov_missed);

endmodule
`default_nettype wire

// ### tb/serial_peer.sv
// Behavioural serial peer on the far side of the shift port's pins.
// Assumes the port samples its pin inputs on core_clk; MSB-first framing.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input  wire logic core_clk,
  input  wire logic sckOut,
  input  wire logic sckOe_n,
  input  wire logic dedicatedOut,
  input  wire logic bidirOut,
  input  wire logic bidirOe_n,
  output logic      sckLine,
  output logic      bidirLine
);
  logic       peerSck   = 1'b1;  // Peer clock drive, high between frames.
  logic       inFrame   = 1'b0;  // Peer is clocking or answering a byte.
  logic       lastSck   = 1'b1;  // Clock line one cycle ago, for edges.
  logic       outBit    = 1'b0;  // Bit the peer presents on the data pin.
  logic       pattern   = 1'b0;  // Toggles so a released pin never looks held.
  logic [7:0] txShift   = 8'h00;
  logic [7:0] rxDed     = 8'h00; // Bits seen on the dedicated output.
  logic [7:0] rxBi      = 8'h00; // Bits seen on the shared data pin.
  logic [7:0] riseCount = 8'h00;

  // idle high clock: the peer only owns the line when the port releases it.
  assign sckLine   = sckOe_n ? peerSck : sckOut;
  // A released data pin carries the peer's bit in a frame or while the port drives the clock, else a moving pattern.
  assign bidirLine = !bidirOe_n ? bidirOut : ((inFrame || !sckOe_n) ? outBit : pattern);

  // Present the next bit after a falling edge, capture both pins on a rise.
  always @(posedge core_clk) begin
    lastSck <= sckLine;
    pattern <= ~pattern;
    if (lastSck && !sckLine) begin
      outBit  <= txShift[7];
      txShift <= {txShift[6:0], 1'b0};
    end
    if (!lastSck && sckLine) begin
      rxDed     <= {rxDed[6:0], dedicatedOut};
      rxBi      <= {rxBi[6:0], bidirLine};
      riseCount <= riseCount + 8'h01;
    end
  end

  // Load the byte to answer with and forget the previous capture.
  task automatic arm(input logic [7:0] b);
    @(posedge core_clk);
    txShift   <= b;
    rxDed     <= 8'h00;
    rxBi      <= 8'h00;
    riseCount <= 8'h00;
  endtask

  // eight clocks after a lead; the caller picks lead and half period.
  task automatic clock_byte(input int lead, input int half);
    @(posedge core_clk);
    inFrame <= 1'b1;
    repeat (lead) @(posedge core_clk);
    repeat (8) begin
      peerSck <= 1'b0;
      repeat (half) @(posedge core_clk);
      peerSck <= 1'b1;
      repeat (half) @(posedge core_clk);
    end
    inFrame <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench: register tasks, a byte queue model and the peer.
// Assumes the package, design files and serial_peer are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import serial_port_pkg::*;
  logic                core_clk      = 1'b0;
  logic                rst           = 1'b1;
  logic [ADDR_W-1:0]   regAddr       = '0;
  logic [NIBBLE_W-1:0] regWrData     = '0;
  logic                regWr         = 1'b0;
  logic                regRd         = 1'b0;
  logic                yIndexLsb     = 1'b0;
  logic                prescalerStop = 1'b0;
  logic                sckLine, bidirLine, sckOut, sckOe_n;
  logic                dedicatedOut, bidirOut, bidirOe_n, serialIrq;
  logic [NIBBLE_W-1:0] regRdData;
  int                  errCount      = 0;
  int                  totalChecks   = 0;
  logic [31:0]         lfsr          = 32'h05d2c20b;
  logic [7:0]          irqRises      = 8'h00; // Peer rises counted at the pulse.
  logic [7:0]          q[$];                  // Bytes the port should hold.

  // Core clock, 8 ns period.
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  serial_shift_port i_dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .yIndexLsb(yIndexLsb),
    .prescalerStop(prescalerStop), .sckIn(sckLine), .bidirIn(bidirLine),
    .regRdData(regRdData), .sckOut(sckOut), .sckOe_n(sckOe_n),
    .dedicatedOut(dedicatedOut), .bidirOut(bidirOut), .bidirOe_n(bidirOe_n),
    .serialIrq(serialIrq));

  serial_peer i_peer (.core_clk(core_clk), .sckOut(sckOut), .sckOe_n(sckOe_n),
    .dedicatedOut(dedicatedOut), .bidirOut(bidirOut), .bidirOe_n(bidirOe_n),
    .sckLine(sckLine), .bidirLine(bidirLine));

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write strobe; a free edge follows so strobes never merge.
  task automatic wr(input logic [2:0] a, input logic [3:0] d, input logic y);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    yIndexLsb <= y;
    regWr     <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // Read data is registered, so it is taken half a cycle after the strobe edge.
  task automatic rd(input logic [2:0] a, input logic y, output logic [3:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    yIndexLsb <= y;
    regRd     <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask

  // Watch a fixed window for the one-cycle completion pulse.
  task automatic wait_irq(input int lim, output logic got);
    got = 1'b0;
    repeat (lim) begin
      @(negedge core_clk);
      if (!got && serialIrq === 1'b1) begin
        got      = 1'b1;
        // The peer registers the clock pin, so it counts the last rise one edge late.
        @(negedge core_clk);
        irqRises = i_peer.riseCount;
      end
    end
  endtask

  task automatic load_byte(input logic [7:0] b);
    wr(ADDR_SERIAL_SHIFT_DATA, b[3:0], 1'b0);
    wr(ADDR_SERIAL_SHIFT_DATA, b[7:4], 1'b1);
  endtask

  // Lower nibble first; the upper read releases the byte.
  task automatic read_pop(input logic [7:0] e);
    logic [3:0] n;
    rd(ADDR_SERIAL_SHIFT_DATA, 1'b0, n);
    check(8'(n), 8'(e[3:0]));
    rd(ADDR_SERIAL_SHIFT_DATA, 1'b1, n);
    check(8'(n), 8'(e[7:4]));
  endtask

  // Internal two-wire send; the port hears its own pin, so it queues b too.
  // Mode 1 stops the prescaler mid-byte, mode 2 expects a full queue first.
  task automatic xfer_int(input logic [7:0] b, input int mode);
    logic got;
    load_byte(b);
    i_peer.arm(8'h00);
    wr(ADDR_SERIAL_CONTROL, 4'h8, 1'b0);
    wr(ADDR_SERIAL_CONTROL, 4'h9, 1'b0);
    if (mode == 1) begin
      wait_irq(40, got);
      @(posedge core_clk);
      prescalerStop <= 1'b1;
      wait_irq(300, got);
      check(8'(got), 8'h00);
      @(posedge core_clk);
      prescalerStop <= 1'b0;
    end
    if (mode == 2) begin
      wait_irq(300, got);
      check(8'(got), 8'h00);
      read_pop(q.pop_front());
    end
    wait_irq(300, got);
    check(8'(got), 8'h01);
    check(irqRises, 8'h08);
    check(i_peer.rxBi, b);
    check(i_peer.rxDed, b);
    check(8'(bidirOe_n), 8'h00);
    check(8'(sckOe_n), 8'h00);
    q.push_back(b);
  endtask

  task automatic finishTest();
    if (errCount == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Bounded run: the whole sequence needs well under half of this.
  initial begin
    repeat (40000) @(posedge core_clk);
    errCount++;
    finishTest();
  end

  initial begin
    logic [3:0] n;
    logic       got;
    logic [7:0] b;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_SERIAL_CONTROL, 1'b0, n);
    check(8'(n), 8'h00);
    rd(3'h5, 1'b0, n);
    check(8'(n), 8'h00);
    check(8'(sckOut), 8'h01);
    // Two-wire internal send, then the flag and the queued copy.
    xfer_int(8'ha5, 0);
    rd(ADDR_SERIAL_CONTROL, 1'b0, n);
    check(8'(n), 8'h09);
    check(8'(sckOut), 8'h01);
    read_pop(q.pop_front());
    // external three-wire receive after the guard.
    load_byte(8'h3c);
    b = rnd();
    i_peer.arm(b);
    wr(ADDR_SERIAL_CONTROL, 4'h2, 1'b0);
    wr(ADDR_SERIAL_CONTROL, 4'h3, 1'b0);
    wait_irq(40, got);
    check(8'(got), 8'h00);
    rd(ADDR_SERIAL_CONTROL, 1'b0, n);
    check(8'(n), 8'h02);
    check(8'(bidirOe_n), 8'h01);
    check(8'(sckOe_n), 8'h01);
    fork
      i_peer.clock_byte(0, 125);
      wait_irq(2100, got);
    join
    check(8'(got), 8'h01);
    check(irqRises, 8'h08);
    check(i_peer.rxDed, 8'h3c);
    read_pop(b);
    // a control write in mid-byte abandons it.
    load_byte(8'hff);
    wr(ADDR_SERIAL_CONTROL, 4'h8, 1'b0);
    wr(ADDR_SERIAL_CONTROL, 4'h9, 1'b0);
    wait_irq(40, got);
    wr(ADDR_SERIAL_CONTROL, 4'h8, 1'b0);
    wait_irq(300, got);
    check(8'(got), 8'h00);
    check(8'(sckOut), 8'h01);
    xfer_int(rnd(), 1);
    // Fill the receive queue, start one more, then drain it.
    while (q.size() < 8) xfer_int(rnd(), 0);
    xfer_int(rnd(), 2);
    while (q.size() > 0) read_pop(q.pop_front());
    // first clock inside the guard costs one shift.
    i_peer.arm(rnd());
    wr(ADDR_SERIAL_CONTROL, 4'h2, 1'b0);
    wr(ADDR_SERIAL_CONTROL, 4'h3, 1'b0);
    fork
      i_peer.clock_byte(0, 125);
      wait_irq(2100, got);
    join
    check(8'(got), 8'h01);
    check(irqRises, 8'h07);
    finishTest();
  end
endmodule
`default_nettype wire
